// ===== src/vam_pkg.sv
// shared constants and carriers for the asynchronous 139 264 kbit/s container mapper
package vam_pkg;
  // container and path overhead geometry (9 rows, 1 overhead byte + 20 blocks of 13 bytes)
  localparam int unsigned ROWS = 9;
  localparam int unsigned BLOCKS = 20;
  localparam int unsigned BLOCK_BYTES = 13;
  localparam int unsigned C4_BYTES = 2340;
  localparam logic [3:0] ROW_LABEL = 4'h2;
  localparam logic [3:0] ROW_MFI = 4'h5;
  localparam logic [4:0] BLK_LAST = 5'h13;
  localparam logic [3:0] OFF_LAST = 4'hC;
  localparam logic [3:0] ROW_LAST = 4'h8;
  // first byte type of each block: 0 = all data, 1 = control/overhead/fixed, 2 = fixed, 3 = data+opportunity
  localparam logic [39:0] BLK_KIND = 40'hE6A6_A6A6_A4;
  // signal label for asynchronous 139 264 kbit/s mapping
  localparam logic [7:0] LABEL_ASYNC = 8'h12;
  localparam logic [2:0] LABEL_PERSIST = 3'h5;
  localparam logic [2:0] C_MAJORITY = 3'h3;
  // elastic stores: depth as address width, half-full used for decisions
  localparam int unsigned SRC_AW = 6;
  localparam int unsigned SNK_AW = 7;
  localparam logic [SRC_AW:0] SRC_HALF = 7'h20;
  localparam logic [SNK_AW:0] SNK_HALF = 8'h40;
  // output bit rate generator: nominal 139 264 kHz from 200 MHz
  localparam longint unsigned CLK_KHZ = 200000;
  localparam longint unsigned TRIB_KHZ = 139264;
  localparam logic [31:0] NCO_STEP = 32'((TRIB_KHZ << 32) / CLK_KHZ);
  localparam logic [31:0] NCO_TRIM = 32'h0000_2000;
  // reset values
  localparam logic [7:0] LABEL_RST = 8'h00;

  // bit class inside the frame
  typedef enum logic [4:0] {
    VAM_POH  = 5'b00001,
    VAM_DATA = 5'b00010,
    VAM_CTRL = 5'b00100,
    VAM_OPP  = 5'b01000,
    VAM_FIX  = 5'b10000
  } vam_cls_e;

  typedef struct packed {
    logic [3:0] row;
    logic poh;
    logic [4:0] blk;
    logic [3:0] off;
    logic [2:0] bit_n;
  } vam_pos_s;

  // frame timing from the upstream trail logic
  typedef struct packed {
    logic bit_en;
    logic frame_start;
  } vam_timing_s;

  // serial adapted information: one bit per bit_en
  typedef struct packed {
    logic data;
    logic bit_en;
    logic frame_start;
  } vam_adapted_s;

  localparam vam_pos_s POS_ZERO = '{row: 4'h0, poh: 1'b1, blk: 5'h00, off: 4'h0, bit_n: 3'h0};
endpackage

// ===== src/vam_bit_fifo.sv
// single-clock elastic store with valid/ready on both sides and a fill level
`timescale 1ns/1ps
module vam_bit_fifo #(
  parameter int unsigned W = 1,
  parameter int unsigned AW = 6
) (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic wr_valid, // write request
  output logic wr_ready, // store not full
  input wire logic [W-1:0] wr_data, // write word
  output logic rd_valid, // store not empty
  input wire logic rd_ready, // read request
  output logic [W-1:0] rd_data, // head word
  output logic [AW:0] level // words held
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  wire wr_go = wr_valid && wr_ready;
  wire rd_go = rd_valid && rd_ready;

  // full when pointers differ only in the wrap bit
  assign level = wptr_ff - rptr_ff;
  assign wr_ready = (level != {1'b1, {AW{1'b0}}});
  assign rd_valid = (wptr_ff != rptr_ff);
  assign rd_data = mem[rptr_ff[AW-1:0]];

  // storage has no reset, only pointers need one
  always_ff @(posedge clock)
  begin
    if (wr_go)
    begin
      mem[wptr_ff[AW-1:0]] <= wr_data;
    end
  end

  // pointer update
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else
    begin
      wptr_ff <= wptr_ff + (AW+1)'(wr_go);
      rptr_ff <= rptr_ff + (AW+1)'(rd_go);
    end
  end
endmodule

// ===== src/vam_mapper.sv
// asynchronous 139 264 kbit/s to container mapper (source) and demapper (sink)
`timescale 1ns/1ps
module vam_mapper (
  input wire logic clock, // 200 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic tributary_clock, // tributary bit clock pin
  input wire logic tributary_data, // tributary data pin
  input wire logic activation_control, // source activation
  input wire vam_pkg::vam_timing_s vc_timing_input, // container bit timing
  output vam_pkg::vam_adapted_s adapted_payload_data, // adapted information out
  output logic adapted_payload_oe, // high while driving the access point
  input wire vam_pkg::vam_adapted_s sink_payload_in, // received adapted information
  input wire logic trail_signal_fail_in, // trail fail from termination
  input wire logic sink_activation_control, // sink activation
  output logic tributary_out_data, // recovered tributary data
  output logic tributary_out_strobe, // one pulse per recovered bit
  output logic payload_mismatch_report, // mismatch to management
  output logic [7:0] accepted_label_value, // accepted label byte
  output logic all_ones_insert_action, // all-ones insertion active
  output logic elastic_slip // sticky store overflow or underflow
);
  // next position inside the frame
  function automatic vam_pkg::vam_pos_s pos_step(input vam_pkg::vam_pos_s p);
    vam_pkg::vam_pos_s n;
    n = p;
    n.bit_n = p.bit_n + 3'h1;
    if (p.bit_n == 3'h7)
    begin
      if (p.poh)
      begin
        n.poh = 1'b0;
        n.blk = 5'h00;
        n.off = 4'h0;
      end
      else if (p.off != vam_pkg::OFF_LAST)
      begin
        n.off = p.off + 4'h1;
      end
      else if (p.blk != vam_pkg::BLK_LAST)
      begin
        n.off = 4'h0;
        n.blk = p.blk + 5'h01;
      end
      else
      begin
        n.poh = 1'b1;
        n.row = (p.row == vam_pkg::ROW_LAST) ? 4'h0 : p.row + 4'h1;
      end
    end
    return n;
  endfunction

  // class of a bit from its position and block kind
  function automatic vam_pkg::vam_cls_e pos_class(input vam_pkg::vam_pos_s p);
    logic [1:0] kind;
    vam_pkg::vam_cls_e c;
    kind = vam_pkg::BLK_KIND[2*p.blk +: 2];
    c = vam_pkg::VAM_DATA;
    if (p.poh)
    begin
      c = vam_pkg::VAM_POH;
    end
    else if (p.off == 4'h0)
    begin
      unique case (kind)
        2'h0: c = vam_pkg::VAM_DATA;
        2'h1: c = (p.bit_n == 3'h0) ? vam_pkg::VAM_CTRL : vam_pkg::VAM_FIX;
        2'h2: c = vam_pkg::VAM_FIX;
        2'h3: c = (p.bit_n == 3'h6) ? vam_pkg::VAM_OPP :
                  (p.bit_n == 3'h7) ? vam_pkg::VAM_FIX : vam_pkg::VAM_DATA;
      endcase
    end
    return c;
  endfunction

  // tributary pins cross into the system clock through two flops each
  logic [1:0] tck_sync_ff;
  logic [1:0] tdat_sync_ff;
  logic tck_prev_ff;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tck_sync_ff <= 2'h0;
      tdat_sync_ff <= 2'h0;
      tck_prev_ff <= 1'b0;
    end
    else
    begin
      tck_sync_ff <= {tck_sync_ff[0], tributary_clock};
      tdat_sync_ff <= {tdat_sync_ff[0], tributary_data};
      tck_prev_ff <= tck_sync_ff[1];
    end
  end
  // data must be stable across the rising edge; both pins share the same two-flop latency
  wire trib_edge = tck_sync_ff[1] && !tck_prev_ff;

  // source frame position, realigned by the upstream frame start
  vam_pkg::vam_pos_s src_pos_ff;
  logic src_just_ff;
  wire src_fire = vc_timing_input.bit_en;
  wire vam_pkg::vam_pos_s src_cur = vc_timing_input.frame_start ? vam_pkg::POS_ZERO : src_pos_ff;
  wire vam_pkg::vam_cls_e src_cls = pos_class(src_cur);
  wire src_row_start = src_cur.poh && (src_cur.bit_n == 3'h0);
  wire src_rd_valid;
  wire src_rd_data;
  wire src_wr_ready;
  wire [vam_pkg::SRC_AW:0] src_level;
  // read on every data bit, and on the opportunity bit unless stuffing
  wire src_rd = src_fire && ((src_cls == vam_pkg::VAM_DATA) ||
                ((src_cls == vam_pkg::VAM_OPP) && !src_just_ff));
  wire nxt_src_just = src_level < vam_pkg::SRC_HALF;

  // elastic store fed by the tributary clock edges
  vam_bit_fifo #(.W(1), .AW(vam_pkg::SRC_AW)) u_src_store (
    .clock(clock),
    .resetn(resetn),
    .wr_valid(trib_edge),
    .wr_ready(src_wr_ready),
    .wr_data(tdat_sync_ff[1]),
    .rd_valid(src_rd_valid),
    .rd_ready(src_rd),
    .rd_data(src_rd_data),
    .level(src_level)
  );

  // adapted bit selection: label, control, data, don't-care positions as zero
  wire label_bit = vam_pkg::LABEL_ASYNC[3'h7 - src_cur.bit_n];
  wire src_out_bit = (src_cls == vam_pkg::VAM_POH) ? ((src_cur.row == vam_pkg::ROW_LABEL) && label_bit) :
                     (src_cls == vam_pkg::VAM_CTRL) ? src_just_ff :
                     (src_rd && src_rd_valid) ? src_rd_data : 1'b0;

  // source position, decision per row and output register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      src_pos_ff <= vam_pkg::POS_ZERO;
      src_just_ff <= 1'b0;
      adapted_payload_data <= '0;
      adapted_payload_oe <= 1'b0;
    end
    else
    begin
      if (src_fire)
      begin
        src_pos_ff <= pos_step(src_cur);
      end
      if (src_fire && src_row_start)
      begin
        src_just_ff <= nxt_src_just;
      end
      adapted_payload_data <= '{data: src_out_bit && activation_control,
                               bit_en: src_fire && activation_control,
                               frame_start: src_fire && vc_timing_input.frame_start && activation_control};
      adapted_payload_oe <= activation_control;
    end
  end

  // sink frame position from the received frame start
  vam_pkg::vam_pos_s snk_pos_ff;
  logic [2:0] c_ones_ff;
  logic [7:0] lab_shift_ff;
  logic [7:0] lab_cand_ff;
  logic [2:0] lab_cnt_ff;
  logic [7:0] lab_acc_ff;
  logic [31:0] nco_ff;
  logic ais_ff;
  wire snk_fire = sink_payload_in.bit_en;
  wire vam_pkg::vam_pos_s snk_cur = sink_payload_in.frame_start ? vam_pkg::POS_ZERO : snk_pos_ff;
  wire vam_pkg::vam_cls_e snk_cls = pos_class(snk_cur);
  wire snk_stuff = c_ones_ff >= vam_pkg::C_MAJORITY;
  // data bits and opportunity bits voted as data go into the store
  wire snk_wr = snk_fire && ((snk_cls == vam_pkg::VAM_DATA) ||
                ((snk_cls == vam_pkg::VAM_OPP) && !snk_stuff));
  wire lab_done = snk_fire && snk_cur.poh && (snk_cur.row == vam_pkg::ROW_LABEL) && (snk_cur.bit_n == 3'h7);
  wire [7:0] lab_byte = {lab_shift_ff[6:0], sink_payload_in.data};
  wire [2:0] nxt_lab_cnt = (lab_byte != lab_cand_ff) ? 3'h1 :
                           (lab_cnt_ff == vam_pkg::LABEL_PERSIST) ? lab_cnt_ff : lab_cnt_ff + 3'h1;
  wire payload_mismatch_defect = (lab_acc_ff != vam_pkg::LABEL_ASYNC);
  wire nxt_ais = trail_signal_fail_in || payload_mismatch_defect || !sink_activation_control;
  wire snk_rd_valid;
  wire snk_rd_data;
  wire snk_wr_ready;
  wire [vam_pkg::SNK_AW:0] snk_level;
  // nominal step, trimmed by store fill so the average follows the far end
  wire [31:0] nco_inc = (snk_level > vam_pkg::SNK_HALF) ? vam_pkg::NCO_STEP + vam_pkg::NCO_TRIM :
                        (snk_level < vam_pkg::SNK_HALF) ? vam_pkg::NCO_STEP - vam_pkg::NCO_TRIM :
                        vam_pkg::NCO_STEP;
  wire [32:0] nco_sum = {1'b0, nco_ff} + {1'b0, nco_inc};
  wire nco_tick = nco_sum[32];
  // the store waits until half full after an empty, which re-centres after a step
  logic snk_run_ff;
  wire snk_rd = nco_tick && snk_run_ff && snk_rd_valid;

  // sink elastic store, written on the gapped input clock
  vam_bit_fifo #(.W(1), .AW(vam_pkg::SNK_AW)) u_snk_store (
    .clock(clock),
    .resetn(resetn),
    .wr_valid(snk_wr),
    .wr_ready(snk_wr_ready),
    .wr_data(sink_payload_in.data),
    .rd_valid(snk_rd_valid),
    .rd_ready(snk_rd),
    .rd_data(snk_rd_data),
    .level(snk_level)
  );

  // sink position, control vote and label persistence
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      snk_pos_ff <= vam_pkg::POS_ZERO;
      c_ones_ff <= 3'h0;
      lab_shift_ff <= vam_pkg::LABEL_RST;
      lab_cand_ff <= vam_pkg::LABEL_RST;
      lab_cnt_ff <= 3'h0;
      lab_acc_ff <= vam_pkg::LABEL_RST;
    end
    else if (snk_fire)
    begin
      snk_pos_ff <= pos_step(snk_cur);
      if (snk_cls == vam_pkg::VAM_POH)
      begin
        c_ones_ff <= 3'h0;
      end
      else if (snk_cls == vam_pkg::VAM_CTRL)
      begin
        c_ones_ff <= c_ones_ff + 3'(sink_payload_in.data);
      end
      lab_shift_ff <= lab_byte;
      if (lab_done)
      begin
        lab_cand_ff <= lab_byte;
        lab_cnt_ff <= nxt_lab_cnt;
        if (nxt_lab_cnt == vam_pkg::LABEL_PERSIST)
        begin
          lab_acc_ff <= lab_byte;
        end
      end
    end
  end

  // evenly spaced read, all-ones and reports; the rate runs on during all-ones
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      nco_ff <= 32'h0000_0000;
      snk_run_ff <= 1'b0;
      ais_ff <= 1'b1;
      tributary_out_data <= 1'b1;
      tributary_out_strobe <= 1'b0;
      payload_mismatch_report <= 1'b0;
      accepted_label_value <= vam_pkg::LABEL_RST;
      all_ones_insert_action <= 1'b1;
      elastic_slip <= 1'b0;
    end
    else
    begin
      nco_ff <= nco_sum[31:0];
      snk_run_ff <= snk_rd_valid && (snk_run_ff || (snk_level >= vam_pkg::SNK_HALF));
      ais_ff <= nxt_ais;
      tributary_out_strobe <= nco_tick;
      tributary_out_data <= (ais_ff || !snk_rd) ? 1'b1 : snk_rd_data;
      payload_mismatch_report <= payload_mismatch_defect && !trail_signal_fail_in && sink_activation_control;
      accepted_label_value <= sink_activation_control ? lab_acc_ff : vam_pkg::LABEL_RST;
      all_ones_insert_action <= nxt_ais;
      // set wins: the flag is sticky until reset
      elastic_slip <= elastic_slip || (trib_edge && !src_wr_ready) || (snk_wr && !snk_wr_ready) ||
                      (src_rd && !src_rd_valid);
    end
  end

  chk_label_bits: assert property (@(posedge clock) disable iff (!resetn)
    (src_fire && activation_control && src_cur.poh && src_cur.row == 4'h2)
    |=> adapted_payload_data.data == vam_pkg::LABEL_ASYNC[3'h7 - $past(src_cur.bit_n)])
    else $error("label bit wrong");
  chk_off_inactive: assert property (@(posedge clock) disable iff (!resetn)
    !activation_control |=> !adapted_payload_oe && !adapted_payload_data.bit_en)
    else $error("access point driven while inactive");
  chk_ctrl_bits: assert property (@(posedge clock) disable iff (!resetn)
    (src_fire && activation_control && src_cls == vam_pkg::VAM_CTRL)
    |=> adapted_payload_data.data == $past(src_just_ff))
    else $error("control bit does not carry decision");
  chk_stuff_noread: assert property (@(posedge clock) disable iff (!resetn)
    (src_fire && src_cls == vam_pkg::VAM_OPP && src_just_ff) |-> !src_rd)
    else $error("store read on stuffed opportunity");
  chk_vote_discard: assert property (@(posedge clock) disable iff (!resetn)
    (snk_fire && snk_cls == vam_pkg::VAM_OPP && c_ones_ff >= 3'h3) |-> !snk_wr)
    else $error("stuff bit written to store");
  chk_ais_onset: assert property (@(posedge clock) disable iff (!resetn)
    (trail_signal_fail_in || payload_mismatch_defect) |=> (ais_ff && all_ones_insert_action) ##1 tributary_out_data)
    else $error("all-ones not inserted");
  chk_inactive_ones: assert property (@(posedge clock) disable iff (!resetn)
    (!sink_activation_control)[*2] |=> tributary_out_data && !payload_mismatch_report)
    else $error("inactive sink not all-ones");
  chk_report_gate: assert property (@(posedge clock) disable iff (!resetn)
    payload_mismatch_report |-> $past(!trail_signal_fail_in) && $past(payload_mismatch_defect))
    else $error("mismatch reported under trail fail");
  chk_rate_kept: assert property (@(posedge clock) disable iff (!resetn)
    ais_ff [*8] |-> $past(nco_tick, 1) == tributary_out_strobe)
    else $error("output rate stopped in all-ones");
endmodule

// ===== sim/vam_far_model.sv
// far-side model: container timing source and tributary bit stream
`timescale 1ns/1ps
module vam_far_model #(
  parameter int unsigned FRAME = 4192, // shortened frame, realigned by frame start
  parameter int unsigned LBL_LAST = 4183 // last bit of the row 2 label byte
) (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic run, // emit container bits
  input wire logic trib_run, // tributary clock running
  output vam_pkg::vam_timing_s timing, // bit enable and frame start
  output logic lbl_mark, // label last bit issued now
  output logic trib_clock, // tributary bit clock
  output logic trib_data // tributary bit
);
  logic [12:0] idx_ff;

  // one container bit per cycle; short frames keep label persistence affordable
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      idx_ff <= 13'h0000;
      timing <= '0;
      lbl_mark <= 1'b0;
    end
    else
    begin
      timing.bit_en <= run;
      timing.frame_start <= run && idx_ff == 13'h0000;
      lbl_mark <= run && idx_ff == 13'(LBL_LAST);
      idx_ff <= (!run || idx_ff == 13'(FRAME - 1)) ? 13'h0000 : idx_ff + 13'h0001;
    end
  end

  // link clock off-grid in phase; it stands still while stopped
  initial
  begin
    trib_clock = 1'b0;
    #3.3;
    forever #80 trib_clock = trib_run ? ~trib_clock : 1'b0;
  end

  // ones while running, low when idle; follows trib_run at once so the first link edge carries a one
  assign trib_data = trib_run;
endmodule

// ===== sim/vc4_async_140m_mapper_tb_top.sv
// self-checking bench for the container mapper with source looped to sink
`timescale 1ns/1ps
module vc4_async_140m_mapper_tb_top;
  localparam int unsigned FRAME = 4192;
  logic clock, resetn, act, sink_act, tsf, run, trib_run, corrupt, mark_d, cap_done;
  logic tck, tdat, lbl_mark, ad_oe, out_d, out_stb, rpt, ais, slip;
  logic [7:0] acc_lbl;
  vam_pkg::vam_timing_s timing;
  vam_pkg::vam_adapted_s ad, snk_in;
  logic cap [0:FRAME-1];
  int n_errors, checks, cyc, cidx, nst;

  vam_far_model far_u (.clock(clock), .resetn(resetn), .run(run), .trib_run(trib_run), .timing(timing),
    .lbl_mark(lbl_mark), .trib_clock(tck), .trib_data(tdat));

  vam_mapper dut_u (.clock(clock), .resetn(resetn), .tributary_clock(tck), .tributary_data(tdat),
    .activation_control(act), .vc_timing_input(timing), .adapted_payload_data(ad), .adapted_payload_oe(ad_oe),
    .sink_payload_in(snk_in), .trail_signal_fail_in(tsf), .sink_activation_control(sink_act),
    .tributary_out_data(out_d), .tributary_out_strobe(out_stb), .payload_mismatch_report(rpt),
    .accepted_label_value(acc_lbl), .all_ones_insert_action(ais), .elastic_slip(slip));

  // loopback; corrupt flips the label's last bit to give 0x13
  assign snk_in = '{data: ad.data ^ (mark_d & corrupt), bit_en: ad.bit_en, frame_start: ad.frame_start};

  always #2.5 clock = ~clock;

  // capture one source frame, then freeze until rearmed
  always @(posedge clock)
  begin
    mark_d <= lbl_mark;
    if (ad.bit_en && !cap_done)
    begin
      cidx = ad.frame_start ? 0 : cidx + 1;
      cap[cidx] = ad.data;
      if (cidx == FRAME - 1)
        cap_done = 1'b1;
    end
  end

  // hang guard, sized above the roughly 70.5k cycles of the sequence
  always @(posedge clock)
  begin
    cyc++;
    if (cyc >= 100000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] byte_at(input int b);
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
      v = {v[6:0], cap[b + i]};
    return v;
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // output rate over 1000 cycles: 696.3 strobes expected; zero bits tell data from all-ones
  task automatic rate_ok(input logic exp_ones);
    int nz;
    nst = 0;
    nz = 0;
    repeat (1000)
    begin
      @(posedge clock);
      #1;
      nst += int'(out_stb);
      nz += int'(out_d === 1'b0);
    end
    cmp1(nst >= 695 && nst <= 698, 1'b1);
    cmp1(nz == 0, exp_ones);
  endtask

  task automatic t_inactive();
    @(posedge clock);
    run <= 1'b1;
    repeat (40)
    begin
      cycles(1);
      cmp1(ad_oe, 1'b0);
      cmp8({5'h00, ad}, 8'h00);
    end
    @(posedge clock);
    run <= 1'b0;
    cycles(4);
  endtask

  // empty store forces stuffing: all control bits one, opportunity bit empty
  task automatic t_src_stuff();
    @(posedge clock);
    act <= 1'b1;
    cap_done = 1'b0;
    cycles(2);
    cmp1(ad_oe, 1'b1);
    @(posedge clock);
    run <= 1'b1;
    cycles(FRAME + 4);
    cmp8(byte_at(4176), 8'h12);
    for (int blk = 1; blk < 18; blk += 4)
      cmp1(cap[(1 + blk * 13) * 8], 1'b1);
    cmp1(cap[1990], 1'b0);
    @(posedge clock);
    run <= 1'b0;
    cycles(4);
    cmp1(slip, 1'b1);
  endtask

  // about 40 tributary bits held: no stuffing, ones read into first data byte
  task automatic t_src_fill();
    @(posedge clock);
    trib_run <= 1'b1;
    cycles(1300);
    cap_done = 1'b0;
    @(posedge clock);
    run <= 1'b1;
    cycles(FRAME + 4);
    cmp1(cap[112], 1'b0);
    cmp8(byte_at(8), 8'hFF);
    cmp8(byte_at(0), 8'h00);
  endtask

  task automatic t_label_ok();
    cycles(7 * FRAME);
    cmp8(acc_lbl, 8'h12);
    cmp1(rpt, 1'b0);
    cmp1(ais, 1'b0);
    rate_ok(1'b0);
  endtask

  task automatic t_fail();
    @(posedge clock);
    tsf <= 1'b1;
    cycles(2);
    cmp1(ais, 1'b1);
    repeat (20)
    begin
      cmp1(out_d, 1'b1);
      cmp1(rpt, 1'b0);
      cycles(1);
    end
    rate_ok(1'b1);
    @(posedge clock);
    tsf <= 1'b0;
    cycles(2);
    cmp1(ais, 1'b0);
  endtask

  task automatic t_mismatch();
    @(posedge clock);
    corrupt <= 1'b1;
    cycles(7 * FRAME);
    cmp8(acc_lbl, 8'h13);
    cmp1(rpt, 1'b1);
    cmp1(ais, 1'b1);
    cmp1(out_d, 1'b1);
    @(posedge clock);
    tsf <= 1'b1;
    cycles(3);
    cmp1(rpt, 1'b0);
    @(posedge clock);
    tsf <= 1'b0;
    cycles(3);
  endtask

  task automatic t_sink_off();
    @(posedge clock);
    sink_act <= 1'b0;
    cycles(3);
    repeat (20)
    begin
      cmp1(out_d, 1'b1);
      cmp1(rpt, 1'b0);
      cmp8(acc_lbl, 8'h00);
      cycles(1);
    end
  endtask

  task automatic test_done();
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reset values checked while reset holds, then the scenarios in turn
  initial
  begin
    clock = 1'b0;
    resetn = 1'b0;
    act = 1'b0;
    sink_act = 1'b1;
    tsf = 1'b0;
    run = 1'b0;
    trib_run = 1'b0;
    corrupt = 1'b0;
    cap_done = 1'b1;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    cidx = 0;
    cycles(4);
    cmp8({5'h00, ad}, 8'h00);
    cmp1(ad_oe, 1'b0);
    cmp1(out_d, 1'b1);
    cmp1(ais, 1'b1);
    cmp1(rpt, 1'b0);
    cmp8(acc_lbl, 8'h00);
    cmp1(slip, 1'b0);
    @(posedge clock);
    resetn <= 1'b1;
    t_inactive();
    t_src_stuff();
    t_src_fill();
    t_label_ok();
    t_fail();
    t_mismatch();
    t_sink_off();
    test_done();
  end
endmodule
